// >>> hbc_top.sv
// Holding brake control: brake commands, override, wiring faults and bedding of brake 2.
// Assumes synchronous inputs, one-cycle start, done and quick stop end pulses.
`timescale 1ns/1ps
`include "hbc_map.svh"
module hbc_top import hbc_pkg::*; #(
    parameter int STAGGER_CYC = (`HBC_STAGGER_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS,
    parameter int LONG_STOP_CYC = (`HBC_LONG_STOP_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS
) (
    input wire logic clk_i,                 // System clock.
    input wire logic rst_n_i,               // Asynchronous reset, active low.
    input wire logic [7:0] addr_i,          // Register byte address.
    input wire logic [31:0] wdata_i,        // Write data.
    input wire logic wr_i,                  // Write strobe.
    input wire logic rd_i,                  // Read strobe.
    output logic [31:0] rdata_o,            // Read data, cycle after rd_i.
    input wire hbc_event_t ev_i,            // Drive events.
    input wire hbc_motion_t mc_i,           // Motion command start and end.
    input wire logic [7:0] drive_state_i,   // Drive state code.
    input wire hbc_monitor_t mon1_i,        // Brake 1 output monitor.
    input wire hbc_monitor_t mon2_i,        // Brake 2 output monitor.
    input wire logic conn_mismatch_i,       // Brake 1 terminal inconsistent.
    output logic brake1_release_o,          // Brake 1 released when high.
    output logic brake2_release_o,          // Brake 2 released when high.
    output logic release_override_signal_o, // Override in force.
    output hbc_bed_t bed_o                  // Bedding motion request.
);
    logic [31:0] ctrl, times, bed_cfg, ext;
    logic [31:0] next_ctrl, next_times, next_bed_cfg, next_ext, next_rdata;
    logic bed_go;
    logic [6:0] fault_clr;
    logic rel1, rel2, out1, out2, pend;
    logic next_rel1, next_rel2, next_out1, next_out2, next_pend;
    logic [19:0] stag, stop_cnt, next_stag, next_stop;
    logic [6:0] flags, next_flags;
    hbc_bed_state_t bst, next_bst;
    logic [7:0] ivl, cyc, next_ivl, next_cyc;
    logic phase, next_phase;
    logic [15:0] prog, next_prog;
    logic [1:0] res, next_res;
    logic t1_done, t2_done;

    // Command codes whose end engages the brake; homing that only defines home keeps it open.
    function automatic logic end_engages(input logic [7:0] code, input logic [7:0] homing);
        case (code)
            8'h01, 8'h02, 8'h03, 8'h05, 8'h0b: end_engages = 1'b1;
            8'h06: end_engages = (homing != `HBC_HOME_DEFINE);
            default: end_engages = 1'b0;
        endcase
    endfunction

    wire fn_on = ctrl[`HBC_CTRL_FUNC];
    wire ovr = ctrl[`HBC_CTRL_OVR];
    wire ext_mode = ctrl[`HBC_CTRL_EXT];
    wire safety = ctrl[`HBC_CTRL_SAFETY];
    wire couple = ctrl[`HBC_CTRL_COUPLE];
    wire [2:0] sel = ctrl[`HBC_CTRL_SEL];
    wire [2:0] mon_en = ctrl[`HBC_CTRL_MON];
    wire [1:0] dir = ctrl[`HBC_CTRL_DIR];
    wire two = (sel == `HBC_SEL_BOTH);
    wire sel1 = (sel == `HBC_SEL_B1) || two;
    wire sel2 = safety && ((sel == `HBC_SEL_B2) || two);
    wire norm = fn_on && !ovr && !ext_mode && (bst == BED_IDLE);
    wire open1 = out1 && t1_done;
    wire open2 = out2 && t2_done;
    wire closed1 = !out1 && t1_done;
    wire closed2 = !out2 && t2_done;

    // Register writes; the bedding start bit is a pulse and is not stored.
    always_comb begin
        next_ctrl = ctrl;
        next_times = times;
        next_bed_cfg = bed_cfg;
        next_ext = ext;
        bed_go = 1'b0;
        fault_clr = 7'h00;
        if (wr_i) begin
            case (addr_i)
                `HBC_REG_CTRL: begin
                    next_ctrl = wdata_i & ~(32'h1 << `HBC_CTRL_BED_GO);
                    bed_go = wdata_i[`HBC_CTRL_BED_GO];
                end
                `HBC_REG_TIMES: next_times = wdata_i;
                `HBC_REG_BED: next_bed_cfg = {16'h0000, wdata_i[15:0]};
                `HBC_REG_EXT: next_ext = {30'h0, wdata_i[1:0]};
                `HBC_REG_FAULT: fault_clr = wdata_i[6:0];
                default: ;
            endcase
        end
        next_rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                `HBC_REG_CTRL: next_rdata = ctrl;
                `HBC_REG_TIMES: next_rdata = times;
                `HBC_REG_BED: next_rdata = bed_cfg;
                `HBC_REG_EXT: next_rdata = ext;
                `HBC_REG_STATUS: next_rdata = {25'h0, release_override_signal_o, closed2, open2,
                                               closed1, open1, out2, out1};
                `HBC_REG_FAULT: next_rdata = {25'h0, flags};
                `HBC_REG_BEDSTAT: next_rdata = {14'h0, res, prog};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file and read data.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `HBC_CTRL_RESET;
            times <= `HBC_TIMES_RESET;
            bed_cfg <= `HBC_BED_RESET;
            ext <= 32'h0000_0000;
            rdata_o <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            times <= next_times;
            bed_cfg <= next_bed_cfg;
            ext <= next_ext;
            rdata_o <= next_rdata;
        end
    end

    wire common_eng = !ev_i.enable || ev_i.lock || ev_i.ebrake || ev_i.qs_done;
    wire end_eng = mc_i.done && end_engages(mc_i.code, ctrl[`HBC_CTRL_HOMING]);
    wire eng1 = common_eng || end_eng || (ev_i.sto && ctrl[`HBC_CTRL_STO_ENG1]);
    wire long_stop = (stop_cnt == 20'(LONG_STOP_CYC - 1));
    // Brake 2 closing without delay; in two-brake mode short stops leave it open.
    wire b2_now = ev_i.sto || (two ? (ev_i.standstill_lost || !ev_i.enable || ev_i.qs_done ||
                  long_stop) : (common_eng || end_eng));
    wire b2_stagger = two && (ev_i.lock || ev_i.ebrake) && rel2;
    wire ovr1 = !(ev_i.sto && safety && !ctrl[`HBC_CTRL_SS1]);

    // Brake decisions. Engage terms are tested first so a coinciding command never reopens brake 1; brake 2 can reopen on lock or ebrake in two-brake mode.
    always_comb begin
        next_rel1 = rel1;
        next_rel2 = rel2;
        next_pend = pend;
        next_stag = stag;
        next_stop = 20'h0;
        if (eng1 || !sel1) begin
            next_rel1 = 1'b0;
        end else if (ev_i.enable && mc_i.start) begin
            next_rel1 = 1'b1;
        end
        if (two && rel2 && !rel1 && ev_i.enable && !long_stop) begin
            next_stop = stop_cnt + 20'h1;
        end
        if (!sel2) begin
            next_rel2 = 1'b0;
            next_pend = 1'b0;
        end else if (!couple) begin
            next_rel2 = !ev_i.sto;
            next_pend = 1'b0;
        end else if (b2_now) begin
            next_rel2 = 1'b0;
            next_pend = 1'b0;
        end else if (pend) begin
            if (stag == 20'h0) begin
                next_rel2 = 1'b0;
                next_pend = 1'b0;
            end else begin
                next_stag = stag - 20'h1;
            end
        end else if (b2_stagger) begin
            next_pend = 1'b1;
            next_stag = 20'(STAGGER_CYC - 1);
        end else if (ev_i.enable && mc_i.start) begin
            next_rel2 = 1'b1;
        end
        // Output source: function off, external, bedding, override, then automatic.
        if (!fn_on) begin
            next_out1 = 1'b0;
            next_out2 = 1'b0;
        end else if (ext_mode) begin
            next_out1 = ext[0];
            next_out2 = ext[1];
        end else if (bst != BED_IDLE) begin
            next_out1 = 1'b1;
            next_out2 = (bst == BED_OPEN);
        end else if (ovr) begin
            next_out1 = ovr1;
            next_out2 = 1'b1;
        end else begin
            next_out1 = next_rel1;
            next_out2 = next_rel2;
        end
        // Brake 2 belongs to the safety module while torque is off, whatever the source.
        next_out1 = next_out1 && sel1;
        next_out2 = next_out2 && sel2 && !ev_i.sto;
    end

    // Brake state registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rel1 <= 1'b0;
            rel2 <= 1'b0;
            out1 <= 1'b0;
            out2 <= 1'b0;
            pend <= 1'b0;
            stag <= 20'h0;
            stop_cnt <= 20'h0;
        end else begin
            rel1 <= next_rel1;
            rel2 <= next_rel2;
            out1 <= next_out1;
            out2 <= next_out2;
            pend <= next_pend;
            stag <= next_stag;
            stop_cnt <= next_stop;
        end
    end

    assign brake1_release_o = out1;
    assign brake2_release_o = out2;
    assign release_override_signal_o = fn_on && ovr && !ext_mode;

    // Settle timers; a brake counts as open or closed only once its time has run.
    hbc_settle_timer #(.TW(16)) u_t1 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(next_out1 != out1),
        .len_i(next_out1 ? times[15:0] : times[31:16]),
        .done_o(t1_done)
    );
    hbc_settle_timer #(.TW(16)) u_t2 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(next_out2 != out2),
        .len_i(next_out2 ? times[15:0] : times[31:16]),
        .done_o(t2_done)
    );

    // Wiring faults stick until acknowledged; a new fault in the clear cycle survives.
    always_comb begin
        next_flags = (flags & ~fault_clr) | {conn_mismatch_i && sel1,
                     {mon2_i.short_ckt, mon2_i.open_ckt, mon2_i.undervolt} & mon_en & {3{sel2}},
                     {mon1_i.short_ckt, mon1_i.open_ckt, mon1_i.undervolt} & mon_en & {3{sel1}}};
    end

    // Fault flag register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags <= 7'h00;
        end else begin
            flags <= next_flags;
        end
    end

    wire both_dir = (dir == `HBC_DIR_BOTH);
    wire cur_neg = (dir == `HBC_DIR_NEG) || (both_dir && phase);
    wire bed_abort = ev_i.sto || ev_i.lock || ev_i.ebrake || !sel2 || !fn_on;
    wire bed_ok = bed_go && (drive_state_i == `HBC_DRIVE_READY) && sel2 && fn_on;

    // Bedding sequence: release, then engage while moving, per interval, direction, cycle.
    always_comb begin
        next_bst = bst;
        next_ivl = ivl;
        next_cyc = cyc;
        next_phase = phase;
        next_prog = prog;
        next_res = res;
        case (bst)
            BED_IDLE: begin
                if (bed_ok) begin
                    next_bst = BED_OPEN;
                    next_ivl = 8'h00;
                    next_cyc = 8'h00;
                    next_phase = 1'b0;
                    next_prog = 16'h0000;
                    next_res = `HBC_RES_BUSY;
                end
            end
            BED_OPEN: begin
                if (open2) begin
                    next_bst = BED_CLOSE;
                end
            end
            BED_CLOSE: begin
                if (closed2) begin
                    next_bst = BED_OPEN;
                    next_prog = prog + 16'h1;
                    next_ivl = ivl + 8'h1;
                    if (ivl + 8'h1 >= bed_cfg[7:0]) begin
                        next_ivl = 8'h00;
                        if (both_dir && !phase) begin
                            next_phase = 1'b1;
                        end else begin
                            next_phase = 1'b0;
                            next_cyc = cyc + 8'h1;
                            if (cyc + 8'h1 >= bed_cfg[15:8]) begin
                                next_bst = BED_IDLE;
                                next_res = `HBC_RES_OK;
                            end
                        end
                    end
                end
            end
            default: next_bst = BED_IDLE;
        endcase
        if (bst != BED_IDLE && bed_abort) begin
            next_bst = BED_IDLE;
            next_res = `HBC_RES_ABORT;
        end
    end

    // Bedding registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bst <= BED_IDLE;
            ivl <= 8'h00;
            cyc <= 8'h00;
            phase <= 1'b0;
            prog <= 16'h0000;
            res <= `HBC_RES_NONE;
        end else begin
            bst <= next_bst;
            ivl <= next_ivl;
            cyc <= next_cyc;
            phase <= next_phase;
            prog <= next_prog;
            res <= next_res;
        end
    end

    assign bed_o.move = (bst != BED_IDLE);
    assign bed_o.dir_neg = (bst != BED_IDLE) && cur_neg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_enable_off_engage: assert property (norm && !ev_i.enable |=> !brake1_release_o)
        else $error("brake 1 stayed released after enable off");
    a_start_release: assert property (norm && sel1 && mc_i.start && !eng1
        |=> brake1_release_o)
        else $error("brake 1 not released by first command");
    a_cmd_end_engage: assert property (norm && mc_i.done && mc_i.code == 8'h0b
        |=> !brake1_release_o)
        else $error("brake 1 not engaged at command end");
    a_sel_b1_only: assert property (sel == `HBC_SEL_B1 |=> !brake2_release_o)
        else $error("brake 2 released while only brake 1 selected");
    a_override_held: assert property (release_override_signal_o && sel1 && !ev_i.sto
        && bst == BED_IDLE |=> brake1_release_o)
        else $error("override did not hold brake 1 released");
    a_sto_b2_closed: assert property (ev_i.sto |=> !brake2_release_o)
        else $error("brake 2 released during safe torque off");
    a_decoupled_b2: assert property (norm && sel2 && !couple && !ev_i.sto
        |=> brake2_release_o)
        else $error("decoupled brake 2 not released");
    a_standstill_b2: assert property (norm && two && sel2 && couple && ev_i.standstill_lost
        |=> !brake2_release_o)
        else $error("brake 2 not engaged after standstill lost");
    a_stagger_gap: assert property (norm && couple && sel2 && b2_stagger && !pend
        && !b2_now && !ev_i.sto |=> brake2_release_o)
        else $error("brakes engaged together on fault");
    a_settle_wait: assert property (times[15:0] != 16'h0 && $rose(brake1_release_o)
        |-> !open1)
        else $error("brake 1 reported open before release time");
    a_fault_sticky: assert property (flags[0] && !fault_clr[0] |=> flags[0])
        else $error("fault flag lost without acknowledge");
    a_bed_pos_first: assert property (bed_o.move && both_dir && !phase |-> !bed_o.dir_neg)
        else $error("bedding did not start in positive direction");
    a_bed_start_gate: assert property (bst == BED_IDLE && drive_state_i != `HBC_DRIVE_READY
        |=> bst == BED_IDLE)
        else $error("bedding started outside ready state");
endmodule

// >>> hbc_map.svh
// Register offsets, field positions, reset values and timing figures of the brake control.
// Assumes a 125 MHz clock and an 8-bit byte address on the register port.
// What this block does
// - After enable, release brake 1 with first motion command; hold until engage event.
// - Engage on power lock, emergency braking, enable off, or end of quick stop.
// - Engage at end of command codes 1,2,3,5,6,11; homing only if method not 5.
// - Selection 1 is brake 1, 2 is brake 2, 4 is both brakes.
// - Override keeps brakes released and reports override on its own signal.
// - With safety module, brake 1 override under safe torque off needs stop-1 permission.
// - Brake 2 is never released by override while safe torque off is active.
// - Detect short circuit, cable break, undervoltage; each check enabled separately.
// - Check brake 1 terminal connection for plausibility and flag a mismatch.
// - Coupling off: brake 2 releases when safe torque off ends, ignoring enable.
// - Coupling on: brake 2 releases with first command, engages like brake 1 plus STO.
// - Bedding moves only in permitted direction; positive first when both are allowed.
// - Bedding engages interval count per direction, repeated for cycle count.
// - Bedding status reports progress in element 1 and result in element 2.
// - Two-brake mode: brake 1 for short stops, brake 2 on long stop or faults.
// - Brakes count as open or closed only after release or engaging time.
// - Brake control can be switched from internal to external commands.
// - Two-brake mode: leaving standstill after brake 1 engaged closes brake 2 at once.
// - Two-brake mode: on fault or emergency braking the two brakes engage at different times.
`ifndef HBC_MAP_SVH
`define HBC_MAP_SVH

`define HBC_REG_CTRL 8'h00
`define HBC_REG_TIMES 8'h04
`define HBC_REG_BED 8'h08
`define HBC_REG_EXT 8'h0c
`define HBC_REG_STATUS 8'h10
`define HBC_REG_FAULT 8'h14
`define HBC_REG_BEDSTAT 8'h18

`define HBC_CTRL_FUNC 0
`define HBC_CTRL_OVR 1
`define HBC_CTRL_EXT 2
`define HBC_CTRL_SAFETY 3
`define HBC_CTRL_SS1 4
`define HBC_CTRL_COUPLE 5
`define HBC_CTRL_BED_GO 6
`define HBC_CTRL_STO_ENG1 7
`define HBC_CTRL_SEL 10:8
`define HBC_CTRL_MON 14:12
`define HBC_CTRL_HOMING 23:16
`define HBC_CTRL_DIR 25:24

`define HBC_CTRL_RESET 32'h0000_0000
`define HBC_TIMES_RESET 32'h0100_0100
`define HBC_BED_RESET 32'h0000_0101

`define HBC_SEL_B1 3'h1
`define HBC_SEL_B2 3'h2
`define HBC_SEL_BOTH 3'h4
`define HBC_DIR_POS 2'h1
`define HBC_DIR_NEG 2'h2
`define HBC_DIR_BOTH 2'h3
`define HBC_HOME_DEFINE 8'h05
`define HBC_DRIVE_READY 8'h02

`define HBC_RES_NONE 2'h0
`define HBC_RES_BUSY 2'h1
`define HBC_RES_OK 2'h2
`define HBC_RES_ABORT 2'h3

`define HBC_CLK_NS 8
`define HBC_STAGGER_NS 200000
`define HBC_LONG_STOP_NS 2000000

`endif

// >>> hbc_pkg.sv
// Types shared by the brake control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hbc_pkg;

    // Drive events that can engage or release the brakes.
    typedef struct packed {
        logic enable;
        logic lock;
        logic ebrake;
        logic qs_done;
        logic sto;
        logic standstill_lost;
    } hbc_event_t;

    // Motion command start and end, with the command code.
    typedef struct packed {
        logic start;
        logic done;
        logic [7:0] code;
    } hbc_motion_t;

    // Wiring monitor inputs of one brake output.
    typedef struct packed {
        logic short_ckt;
        logic open_ckt;
        logic undervolt;
    } hbc_monitor_t;

    // Motion request made while bedding in brake 2.
    typedef struct packed {
        logic move;
        logic dir_neg;
    } hbc_bed_t;

    typedef enum logic [1:0] {
        BED_IDLE,
        BED_OPEN,
        BED_CLOSE
    } hbc_bed_state_t;

endpackage

// >>> hbc_settle_timer.sv
// Down counter that marks a brake as settled after its release or engaging time.
// Assumes the load pulse arrives when the brake command changes.
`timescale 1ns/1ps
module hbc_settle_timer import hbc_pkg::*; #(
    parameter int TW = 16
) (
    input wire logic clk_i,            // System clock.
    input wire logic rst_n_i,          // Asynchronous reset, active low.
    input wire logic load_i,           // Restart the wait.
    input wire logic [TW-1:0] len_i,   // Wait length in cycles.
    output logic done_o                // Wait has elapsed.
);
    logic [TW-1:0] cnt;
    logic [TW-1:0] next_cnt;

    // A reload during a running wait restarts it, so a quick toggle is never reported settled.
    always_comb begin
        next_cnt = cnt;
        if (load_i) begin
            next_cnt = len_i;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // Counter register.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign done_o = (cnt == '0) && !load_i;
endmodule

// >>> hbc_brake_model.sv
// Behavioural brake coils and wiring monitor at the far side of the brake outputs.
// Assumes the bench injects wiring faults; all monitor codes are active high.
`timescale 1ns/1ps
module hbc_brake_model import hbc_pkg::*; (
    input wire logic brake1_release_i, // Brake 1 drive.
    input wire logic fault_short_i,    // Injected brake 1 short.
    input wire logic fault_uv_i,       // Injected supply sag.
    input wire logic miswire_i,        // Injected terminal mismatch.
    output hbc_monitor_t mon1_o,       // Brake 1 monitor.
    output hbc_monitor_t mon2_o,       // Brake 2 monitor.
    output logic conn_mismatch_o       // Terminal check.
);
    // Brake 1 undervolt only shows while its coil is energised, as a real supply sag would; brake 2 undervolt follows the sag.
    assign mon1_o = {fault_short_i, 1'b0, fault_uv_i & brake1_release_i};
    assign mon2_o = {2'h0, fault_uv_i};
    assign conn_mismatch_o = miswire_i;
endmodule

// >>> holding_brake_control_test.sv
// Self-checking bench for the holding brake control.
// Assumes the register map header and a far-side brake model beside the design.
`timescale 1ns/1ps
`include "hbc_map.svh"
module holding_brake_control_test import hbc_pkg::*;;
    logic clk_i, rst_n_i, wr_i, rd_i, conn_mismatch_i, b1, b2, ovr, f_sh, f_uv, f_mw;
    logic [7:0] addr_i, drive_state_i, code, hom;
    logic [31:0] wdata_i, rdata_o, d;
    hbc_event_t ev_i;
    hbc_motion_t mc_i;
    hbc_monitor_t mon1_i, mon2_i;
    hbc_bed_t bed;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0b};
    logic [7:0] ra [4] = '{`HBC_REG_CTRL, `HBC_REG_TIMES, `HBC_REG_BED, 8'h40};
    logic [31:0] rv [4] = '{`HBC_CTRL_RESET, `HBC_TIMES_RESET, `HBC_BED_RESET, 32'h0};

    hbc_top #(.STAGGER_CYC(4), .LONG_STOP_CYC(20)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ev_i(ev_i), .mc_i(mc_i), .drive_state_i(drive_state_i), .mon1_i(mon1_i),
        .mon2_i(mon2_i), .conn_mismatch_i(conn_mismatch_i), .brake1_release_o(b1),
        .brake2_release_o(b2), .release_override_signal_o(ovr), .bed_o(bed));
    hbc_brake_model u_brk (.brake1_release_i(b1), .fault_short_i(f_sh), .fault_uv_i(f_uv),
        .miswire_i(f_mw), .mon1_o(mon1_i), .mon2_o(mon2_i), .conn_mismatch_o(conn_mismatch_i));

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    // Expected engage at a command end; homing with define-home keeps the brake open.
    function automatic logic ends(input logic [7:0] c, input logic [7:0] h);
        return (c inside {8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0b}) &&
            !(c == 8'h06 && h == `HBC_HOME_DEFINE);
    endfunction

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i) addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i) wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i) addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i) rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic end_of_test();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog; the sequence needs about 250 cycles.
    initial begin
        #160000;
        n_errors++;
        end_of_test();
    end

    // Main sequence: reset values, command ends, engage events, override, faults.
    initial begin
        clk_i = 0; rst_n_i = 0; addr_i = '0; wdata_i = '0; wr_i = 0; rd_i = 0;
        ev_i = '0; mc_i = '0; drive_state_i = `HBC_DRIVE_READY; f_sh = 0; f_uv = 0; f_mw = 0;
        void'($urandom(32'h95f7));
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(ra[i], d);
            cmp_word(d, rv[i]);
        end
        for (int i = 0; i < 14; i++) begin
            code = (i < 6) ? codes[i] : 8'($urandom_range(15));
            hom = $urandom_range(1) ? `HBC_HOME_DEFINE : 8'($urandom_range(4));
            wr(`HBC_REG_CTRL, 32'h101 | {8'h0, hom, 16'h0});
            @(posedge clk_i) ev_i.enable <= 1'b1;
            mc_i.start <= 1'b1;
            drive_state_i <= 8'($urandom);
            @(posedge clk_i) mc_i.start <= 1'b0;
            #1 cmp_bit(b1, 1'b1);
            @(posedge clk_i) mc_i.done <= 1'b1;
            mc_i.code <= code;
            @(posedge clk_i) mc_i.done <= 1'b0;
            #1 cmp_bit(b1, !ends(code, hom));
        end
        @(posedge clk_i) ev_i.lock <= 1'b1;
        mc_i.start <= 1'b1;
        @(posedge clk_i) mc_i.start <= 1'b0;
        #1 cmp_bit(b1, 1'b0);
        for (int j = 0; j < 4; j++) begin
            @(posedge clk_i) mc_i.start <= 1'b1;
            ev_i <= 6'h20;
            @(posedge clk_i) mc_i.start <= 1'b0;
            ev_i.lock <= (j == 0);
            ev_i.ebrake <= (j == 1);
            ev_i.enable <= (j != 2);
            ev_i.qs_done <= (j == 3);
            #1 cmp_bit(b1, 1'b1);
            @(posedge clk_i) ev_i <= '0;
            #1 cmp_bit(b1, 1'b0);
        end
        wr(`HBC_REG_CTRL, 32'h103);
        @(posedge clk_i) #1 cmp_bit(ovr, 1'b1);
        cmp_bit(b1, 1'b1);
        wr(`HBC_REG_CTRL, 32'h105);
        wr(`HBC_REG_EXT, 32'h1);
        @(posedge clk_i) #1 cmp_bit(b1, 1'b1);
        wr(`HBC_REG_CTRL, 32'h209);
        @(posedge clk_i) ev_i.sto <= 1'b1;
        @(posedge clk_i) ev_i.sto <= 1'b0;
        @(posedge clk_i) #1 cmp_bit(b2, 1'b1);
        cmp_bit(b1, 1'b0);
        wr(`HBC_REG_CTRL, 32'h20b);
        @(posedge clk_i) ev_i.sto <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 cmp_bit(b2, 1'b0);
        wr(`HBC_REG_CTRL, 32'h7101);
        @(posedge clk_i) f_sh <= 1'b1;
        @(posedge clk_i) f_sh <= 1'b0;
        f_mw <= 1'b1;
        @(posedge clk_i) f_mw <= 1'b0;
        rd(`HBC_REG_FAULT, d);
        cmp_word(d, 32'h44);
        wr(`HBC_REG_FAULT, 32'h44);
        rd(`HBC_REG_FAULT, d);
        cmp_word(d, 32'h0);
        // Bedding of brake 2: both directions, two intervals, one cycle, so four engages.
        @(posedge clk_i) ev_i <= '0;
        drive_state_i <= `HBC_DRIVE_READY;
        wr(`HBC_REG_TIMES, 32'h0004_0004);
        wr(`HBC_REG_BED, 32'h0000_0102);
        wr(`HBC_REG_CTRL, 32'h0300_0209);
        wr(`HBC_REG_CTRL, 32'h0300_0249);
        #1 cmp_bit(bed.move, 1'b1);
        cmp_bit(bed.dir_neg, 1'b0);
        repeat (80) @(posedge clk_i);
        #1 cmp_bit(bed.move, 1'b0);
        rd(`HBC_REG_BEDSTAT, d);
        cmp_word(d, 32'h0002_0004);
        // Two-brake mode: a command end leaves brake 2 open, a lock closes it later.
        wr(`HBC_REG_CTRL, 32'h0000_0429);
        @(posedge clk_i) ev_i.enable <= 1'b1;
        mc_i.start <= 1'b1;
        @(posedge clk_i) mc_i.start <= 1'b0;
        mc_i.done <= 1'b1;
        mc_i.code <= 8'h01;
        @(posedge clk_i) mc_i.done <= 1'b0;
        ev_i.lock <= 1'b1;
        #1 cmp_bit(b1, 1'b0);
        cmp_bit(b2, 1'b1);
        @(posedge clk_i) #1 cmp_bit(b2, 1'b1);
        repeat (4) @(posedge clk_i);
        #1 cmp_bit(b2, 1'b0);
        end_of_test();
    end
endmodule
